// File: verilog/bcw_bus_comm_watchdog.sv
// Communication watchdog with command, timeout and status registers.
// Assumes requests arrive as one-cycle strobes synchronous to CLK_SYS_IN
// and that mode and trigger options come from the configuration logic.
//
// Function
// - Command register reads never return the last written command.
// - Start while no timeout configured answers exception 0x03.
// - Explicit mode: start or stop when timed out answers 0x03.
// - Otherwise start reloads the full count and enters counting.
// - Allowed stop 0x55AA halts countdown and enters idle.
// - Stop while no timeout configured answers exception 0x03.
// - Auto-run mode: every stop answers exception 0x03.
// - Repeated stop while idle changes nothing and raises no error.
// - Explicit mode: reset 0xAAAA when timed out enters idle.
// - Reset in any other state or mode answers exception 0x03.
// - Timeout register is 16 bits of 1 ms, resetting to zero.
// - With zero timeout the unit stays unconfigured and never starts.
// - Timeout writes refused with 0x01 while counting or timed out.
// - Status codes: FFFF unconfigured, 0 idle, 1 counting, 2 timed out.
// - Only a nonzero timeout write leaves the unconfigured state.
// - Explicit mode: configured idle unit starts counting on start.
// - Auto-run mode never reports idle; it starts counting itself.
// - Counting ends when the timeout elapses, entering timed out.
// - Auto-run mode: trigger in timed out restarts counting.
// - Valid requests trigger, except status access without status trigger option, and explicit option.
// - Mode comes from configuration bit 7.
// - No trigger within timeout while counting starts timeout response.
// - Auto-run mode only takes effect while timeout is nonzero.
`default_nettype none
module bcw_bus_comm_watchdog #(
	parameter int TICK_CYCLES = bcw_pkg::TICK_CYCLES_DEF
) (
	input wire logic CLK_SYS_IN,
	input wire logic SYS_RST_IN,
	input wire bcw_pkg::bcw_req_type REQ_IN,
	output var bcw_pkg::bcw_rsp_type RSP_OUT,
	input wire logic EXT_TRIGGER_IN,
	input wire logic MODE_AUTO_RUN_IN,
	input wire logic EXPLICIT_TRIGGER_IN,
	input wire logic STATUS_TRIGGER_IN,
	output logic TIMEOUT_EVENT_OUT,
	output logic TIMED_OUT_OUT
);
	import bcw_pkg::*;

	localparam int PW = (TICK_CYCLES > 2) ? $clog2(TICK_CYCLES) : 1;

	// ==========================================================
	// Elaboration check
	if (TICK_CYCLES < 2) begin : g_tick_check
		$error("TICK_CYCLES must be at least 2");
	end

	// ==========================================================
	// Storage
	bcw_state_type st_q, st_d;
	logic [15:0] timeout_q;
	logic [15:0] count_q;
	logic [PW-1:0] presc_q;
	logic tick;
	logic load;
	logic [15:0] load_val;
	logic tmo_we;
	logic exc;
	logic [7:0] exc_code;
	logic [15:0] rdata;
	logic start_ok;
	logic trig;
	logic expire;
	logic [15:0] state_code;

	// Status code of the current state
	always_comb begin
		case (st_q)
			state_no_timeout: state_code = CODE_NO_TIMEOUT;
			state_idle: state_code = CODE_IDLE;
			state_counting: state_code = CODE_COUNTING;
			state_timed_out: state_code = CODE_TIMED_OUT;
			default: state_code = CODE_NO_TIMEOUT;
		endcase
	end

	// Millisecond tick, only while counting
	assign tick = (st_q == state_counting) && (presc_q == PW'(TICK_CYCLES - 1));
	assign expire = tick && (count_q == COUNT_LAST);

	// ==========================================================
	// Request decode and next state
	always_comb begin
		st_d = st_q;
		load = 1'b0;
		tmo_we = 1'b0;
		exc = 1'b0;
		exc_code = EXC_NONE;
		rdata = 16'h0000;
		start_ok = 1'b0;
		trig = 1'b0;
		load_val = timeout_q;
		// Autonomous steps
		if (expire) begin
			st_d = state_timed_out;
		end
		if (MODE_AUTO_RUN_IN && st_q == state_idle) begin
			st_d = state_counting;
			load = 1'b1;
		end
		if (REQ_IN.valid) begin
			case (REQ_IN.addr)
				ADDR_COMMAND_WORD: begin
					if (!REQ_IN.write) begin
						rdata = CMD_READ_VALUE;
					end else begin
						case (REQ_IN.wdata)
							CMD_START: begin
								if (st_q == state_no_timeout) begin
									exc = 1'b1;
								end else if (!MODE_AUTO_RUN_IN && st_q == state_timed_out) begin
									exc = 1'b1;
								end else begin
									st_d = state_counting;
									load = 1'b1;
									start_ok = 1'b1;
								end
							end
							CMD_STOP: begin
								if (MODE_AUTO_RUN_IN) begin
									exc = 1'b1;
								end else if (st_q == state_no_timeout) begin
									exc = 1'b1;
								end else if (st_q == state_timed_out) begin
									exc = 1'b1;
								end else begin
									st_d = state_idle;
									load = 1'b0;
								end
							end
							CMD_RESET: begin
								if (!MODE_AUTO_RUN_IN && st_q == state_timed_out) begin
									st_d = state_idle;
								end else begin
									exc = 1'b1;
								end
							end
							default: begin
								exc = 1'b1;
							end
						endcase
						exc_code = exc ? EXC_ILLEGAL_VALUE : EXC_NONE;
					end
				end
				ADDR_TIMEOUT_MS: begin
					if (!REQ_IN.write) begin
						rdata = timeout_q;
					end else if (st_q == state_counting || st_q == state_timed_out) begin
						exc = 1'b1;
						exc_code = EXC_ILLEGAL_FUNCTION;
					end else begin
						tmo_we = 1'b1;
						load_val = REQ_IN.wdata;
						if (REQ_IN.wdata == TIMEOUT_RESET) begin
							st_d = state_no_timeout;
							load = 1'b0;
						end else if (MODE_AUTO_RUN_IN) begin
							st_d = state_counting;
							load = 1'b1;
						end else begin
							st_d = state_idle;
							load = 1'b0;
						end
					end
				end
				ADDR_STATE_CODE: begin
					if (!REQ_IN.write) begin
						rdata = state_code;
					end else begin
						exc = 1'b1;
						exc_code = EXC_ILLEGAL_FUNCTION;
					end
				end
				default: begin
					exc = 1'b1;
					exc_code = EXC_ILLEGAL_ADDRESS;
				end
			endcase
		end
		// Trigger qualification
		if (EXPLICIT_TRIGGER_IN) begin
			trig = start_ok;
		end else begin
			trig = EXT_TRIGGER_IN || (REQ_IN.valid && !exc && REQ_IN.addr != ADDR_STATE_CODE);
		end
		if (REQ_IN.valid && !REQ_IN.write && REQ_IN.addr == ADDR_STATE_CODE && STATUS_TRIGGER_IN) begin
			trig = 1'b1;
		end
		// A trigger in the expiry cycle still arrived in time
		if (trig && (st_d == state_counting || (expire && st_d == state_timed_out))) begin
			st_d = state_counting;
			load = 1'b1;
		end
		if (trig && MODE_AUTO_RUN_IN && st_q == state_timed_out && st_d == state_timed_out) begin
			st_d = state_counting;
			load = 1'b1;
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			st_q <= state_no_timeout;
		end else begin
			st_q <= st_d;
		end
	end

	// Timeout register
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			timeout_q <= TIMEOUT_RESET;
		end else if (tmo_we) begin
			timeout_q <= REQ_IN.wdata;
		end
	end

	// Countdown and prescaler
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			count_q <= TIMEOUT_RESET;
			presc_q <= '0;
		end else if (load) begin
			count_q <= load_val;
			presc_q <= '0;
		end else if (st_q == state_counting) begin
			presc_q <= tick ? '0 : presc_q + PW'(1);
			if (tick) begin
				count_q <= count_q - 16'h0001;
			end
		end else begin
			presc_q <= '0;
		end
	end

	// Answer register
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			RSP_OUT <= '0;
		end else begin
			RSP_OUT.done <= REQ_IN.valid;
			RSP_OUT.exc <= REQ_IN.valid && exc;
			RSP_OUT.exc_code <= REQ_IN.valid ? exc_code : EXC_NONE;
			RSP_OUT.rdata <= (REQ_IN.valid && !exc) ? rdata : 16'h0000;
		end
	end

	// Timeout response outputs
	always_ff @(posedge CLK_SYS_IN) begin
		if (SYS_RST_IN) begin
			TIMEOUT_EVENT_OUT <= 1'b0;
			TIMED_OUT_OUT <= 1'b0;
		end else begin
			TIMEOUT_EVENT_OUT <= (st_q == state_counting) && (st_d == state_timed_out);
			TIMED_OUT_OUT <= (st_d == state_timed_out);
		end
	end

	// ==========================================================
	// Assertions
	a_cmd_read_zero: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REQ_IN.valid && !REQ_IN.write && REQ_IN.addr == ADDR_COMMAND_WORD
		|=> RSP_OUT.done && !RSP_OUT.exc && RSP_OUT.rdata == CMD_READ_VALUE)
		else $error("command register read returned data");

	a_start_unconf: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REQ_IN.valid && REQ_IN.write && REQ_IN.addr == ADDR_COMMAND_WORD
		&& REQ_IN.wdata == CMD_START && st_q == state_no_timeout
		|=> RSP_OUT.exc && RSP_OUT.exc_code == EXC_ILLEGAL_VALUE && st_q == state_no_timeout)
		else $error("start accepted without timeout");

	a_start_expired: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REQ_IN.valid && REQ_IN.write && REQ_IN.addr == ADDR_COMMAND_WORD
		&& (REQ_IN.wdata == CMD_START || REQ_IN.wdata == CMD_STOP)
		&& !MODE_AUTO_RUN_IN && st_q == state_timed_out
		|=> RSP_OUT.exc_code == EXC_ILLEGAL_VALUE && st_q == state_timed_out)
		else $error("start or stop accepted while timed out");

	a_start_reload: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REQ_IN.valid && REQ_IN.write && REQ_IN.addr == ADDR_COMMAND_WORD
		&& REQ_IN.wdata == CMD_START && st_q == state_idle
		|=> st_q == state_counting && count_q == timeout_q && !RSP_OUT.exc)
		else $error("start did not reload the count");

	a_stop_auto: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REQ_IN.valid && REQ_IN.write && REQ_IN.addr == ADDR_COMMAND_WORD
		&& REQ_IN.wdata == CMD_STOP && MODE_AUTO_RUN_IN
		|=> RSP_OUT.exc && RSP_OUT.exc_code == EXC_ILLEGAL_VALUE)
		else $error("stop accepted in auto-run mode");

	a_reset_idle: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REQ_IN.valid && REQ_IN.write && REQ_IN.addr == ADDR_COMMAND_WORD
		&& REQ_IN.wdata == CMD_RESET && !MODE_AUTO_RUN_IN && st_q == state_timed_out
		|=> st_q == state_idle && !RSP_OUT.exc)
		else $error("reset did not return to idle");

	a_timeout_locked: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REQ_IN.valid && REQ_IN.write && REQ_IN.addr == ADDR_TIMEOUT_MS
		&& (st_q == state_counting || st_q == state_timed_out)
		|=> RSP_OUT.exc_code == EXC_ILLEGAL_FUNCTION && $stable(timeout_q))
		else $error("timeout written while active");

	a_auto_not_idle: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		MODE_AUTO_RUN_IN && $past(MODE_AUTO_RUN_IN) && !$past(SYS_RST_IN) |-> st_q != state_idle)
		else $error("idle reported in auto-run mode");

	a_expiry_entry: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		expire && !REQ_IN.valid && !EXT_TRIGGER_IN
		|=> st_q == state_timed_out && TIMEOUT_EVENT_OUT ##1 !TIMEOUT_EVENT_OUT)
		else $error("expiry not entered on count end");

	a_trigger_reload: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		EXT_TRIGGER_IN && !EXPLICIT_TRIGGER_IN && !REQ_IN.valid && st_q == state_counting
		|=> st_q == state_counting && count_q == timeout_q && presc_q == '0)
		else $error("trigger did not reload count");

	a_reset_refused: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REQ_IN.valid && REQ_IN.write && REQ_IN.addr == ADDR_COMMAND_WORD
		&& REQ_IN.wdata == CMD_RESET && (MODE_AUTO_RUN_IN || st_q != state_timed_out)
		|=> RSP_OUT.exc && RSP_OUT.exc_code == EXC_ILLEGAL_VALUE)
		else $error("reset accepted outside timed out");

	a_stop_to_idle: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REQ_IN.valid && REQ_IN.write && REQ_IN.addr == ADDR_COMMAND_WORD
		&& REQ_IN.wdata == CMD_STOP && !MODE_AUTO_RUN_IN
		&& (st_q == state_counting || st_q == state_idle)
		|=> st_q == state_idle && !RSP_OUT.exc)
		else $error("allowed stop did not reach idle");

	a_zero_unconf: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		timeout_q == TIMEOUT_RESET |-> st_q == state_no_timeout)
		else $error("configured state with zero timeout");

	a_status_running: assert property (@(posedge CLK_SYS_IN) disable iff (SYS_RST_IN)
		REQ_IN.valid && !REQ_IN.write && REQ_IN.addr == ADDR_STATE_CODE
		&& st_q == state_counting
		|=> RSP_OUT.rdata == CODE_COUNTING)
		else $error("wrong status code while counting");
endmodule
`default_nettype wire

// File: verilog/bcw_pkg.sv
// Shared constants and types for the bus communication watchdog.
// Assumes a protocol engine that turns master register requests into
// single-cycle request strobes and accepts one answer strobe per request.
`default_nettype none
package bcw_pkg;
	// ==========================================================
	// Register addresses
	localparam logic [15:0] ADDR_COMMAND_WORD = 16'hFA00;
	localparam logic [15:0] ADDR_TIMEOUT_MS = 16'hFA01;
	localparam logic [15:0] ADDR_STATE_CODE = 16'hFA02;

	// ==========================================================
	// Command codes and reset values
	localparam logic [15:0] CMD_START = 16'h5555;
	localparam logic [15:0] CMD_STOP = 16'h55AA;
	localparam logic [15:0] CMD_RESET = 16'hAAAA;
	localparam logic [15:0] TIMEOUT_RESET = 16'h0000;
	localparam logic [15:0] CMD_READ_VALUE = 16'h0000;

	// ==========================================================
	// Status codes reported for each state
	localparam logic [15:0] CODE_NO_TIMEOUT = 16'hFFFF;
	localparam logic [15:0] CODE_IDLE = 16'h0000;
	localparam logic [15:0] CODE_COUNTING = 16'h0001;
	localparam logic [15:0] CODE_TIMED_OUT = 16'h0002;

	// ==========================================================
	// Exception codes
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_ILLEGAL_FUNCTION = 8'h01;
	localparam logic [7:0] EXC_ILLEGAL_ADDRESS = 8'h02;
	localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;

	// ==========================================================
	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [15:0] COUNT_LAST = 16'h0001;

	// ==========================================================
	// Types
	typedef enum logic [3:0] {
		state_no_timeout = 4'h1,
		state_idle = 4'h2,
		state_counting = 4'h4,
		state_timed_out = 4'h8
	} bcw_state_type;

	typedef struct packed {
		logic valid;
		logic write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} bcw_req_type;

	typedef struct packed {
		logic done;
		logic exc;
		logic [7:0] exc_code;
		logic [15:0] rdata;
	} bcw_rsp_type;
endpackage
`default_nettype wire

// File: testbench/bcw_master_model.sv
// Register master model that issues requests to the watchdog port.
// Assumes each taken request is answered on the edge that takes it.
`default_nettype none
module bcw_master_model (
	input wire logic CLK_SYS_IN,
	input wire bcw_pkg::bcw_rsp_type RSP_IN,
	output var bcw_pkg::bcw_req_type REQ_OUT
);
	timeunit 1ns;
	timeprecision 1ps;
	import bcw_pkg::*;

	// ==========================================================
	// Request driver
	// Idle bus at time zero
	initial begin
		REQ_OUT <= '0;
	end

	// One request held to its taking edge, then released
	task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
		output logic dn, output logic ex, output logic [7:0] code, output logic [15:0] rd);
		@(posedge CLK_SYS_IN);
		REQ_OUT <= {1'b1, w, a, d};
		@(posedge CLK_SYS_IN);
		REQ_OUT <= {1'b0, ~w, ~a, ~d}; // Released lines show inverse
		#1;
		dn = RSP_IN.done;
		ex = RSP_IN.exc;
		code = RSP_IN.exc_code;
		rd = RSP_IN.rdata;
	endtask
endmodule
`default_nettype wire

// File: testbench/tb_top.sv
// Self-checking bench for the bus communication watchdog.
// Assumes the master model drives requests; short tick of 4 cycles.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import bcw_pkg::*;

	// ==========================================================
	// Signals and instances
	localparam int TICKS = 4;
	logic clk;
	logic rst;
	logic ext_trig;
	logic mode_auto;
	logic exp_trig;
	logic stat_trig;
	logic tmo_event;
	logic timed_out;
	bcw_req_type req;
	bcw_rsp_type rsp;
	int failures = 0;
	int n_compared = 0;
	int n_events = 0;

	bcw_bus_comm_watchdog #(.TICK_CYCLES(TICKS)) i_bcw_bus_comm_watchdog (
		.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .REQ_IN(req), .RSP_OUT(rsp),
		.EXT_TRIGGER_IN(ext_trig), .MODE_AUTO_RUN_IN(mode_auto),
		.EXPLICIT_TRIGGER_IN(exp_trig), .STATUS_TRIGGER_IN(stat_trig),
		.TIMEOUT_EVENT_OUT(tmo_event), .TIMED_OUT_OUT(timed_out));
	bcw_master_model i_bcw_master_model (.CLK_SYS_IN(clk), .RSP_IN(rsp), .REQ_OUT(req));

	// Clock of 4 ns
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Counts expiry pulses
	always @(posedge clk) begin
		if (tmo_event === 1'b1) n_events++;
	end

	// ==========================================================
	// Tasks
	task automatic check(input logic [25:0] got, input logic [25:0] exp);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
		input logic [7:0] ec, input logic [15:0] er);
		logic dn;
		logic ex;
		logic [7:0] c;
		logic [15:0] r;
		i_bcw_master_model.xfer(w, a, d, dn, ex, c, r);
		check({dn, ex, c, r}, {1'b1, ec != EXC_NONE, ec, er});
	endtask

	task automatic cmd(input logic [15:0] d, input logic [7:0] ec);
		acc(1'b1, ADDR_COMMAND_WORD, d, ec, 16'h0000);
	endtask

	task automatic st(input logic [15:0] e);
		acc(1'b0, ADDR_STATE_CODE, 16'h0000, EXC_NONE, e);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic trig();
		@(posedge clk) ext_trig <= 1'b1;
		@(posedge clk) ext_trig <= 1'b0;
	endtask

	task automatic wrap_up();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hang guard
	initial begin
		#20000;
		failures++;
		wrap_up();
	end

	// ==========================================================
	// Main sequence
	initial begin
		rst <= 1'b1;
		ext_trig <= 1'b0;
		mode_auto <= 1'b0;
		exp_trig <= 1'b0;
		stat_trig <= 1'b0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		st(CODE_NO_TIMEOUT);
		acc(1'b0, ADDR_TIMEOUT_MS, 16'h0000, EXC_NONE, 16'h0000);
		cmd(CMD_START, EXC_ILLEGAL_VALUE);
		cmd(CMD_STOP, EXC_ILLEGAL_VALUE);
		cmd(CMD_RESET, EXC_ILLEGAL_VALUE);
		st(CODE_NO_TIMEOUT);
		acc(1'b1, ADDR_TIMEOUT_MS, 16'hFFFF, EXC_NONE, 16'h0000);
		acc(1'b0, ADDR_TIMEOUT_MS, 16'h0000, EXC_NONE, 16'hFFFF);
		acc(1'b1, ADDR_TIMEOUT_MS, 16'h0003, EXC_NONE, 16'h0000);
		st(CODE_IDLE);
		cmd(CMD_STOP, EXC_NONE);
		cmd(CMD_STOP, EXC_NONE);
		cmd(CMD_START, EXC_NONE);
		acc(1'b0, ADDR_COMMAND_WORD, 16'h0000, EXC_NONE, CMD_READ_VALUE);
		st(CODE_COUNTING);
		acc(1'b1, ADDR_TIMEOUT_MS, 16'h0007, EXC_ILLEGAL_FUNCTION, 16'h0000);
		acc(1'b0, ADDR_TIMEOUT_MS, 16'h0000, EXC_NONE, 16'h0003);
		// Pulses closer than 12 cycles keep it counting
		repeat (6) begin
			idle(6);
			trig();
		end
		st(CODE_COUNTING);
		idle(30);
		#1;
		check({25'h0000000, timed_out}, 26'h0000001);
		check(n_events[25:0], 26'h0000001);
		st(CODE_TIMED_OUT);
		cmd(CMD_START, EXC_ILLEGAL_VALUE);
		cmd(CMD_STOP, EXC_ILLEGAL_VALUE);
		acc(1'b1, ADDR_TIMEOUT_MS, 16'h0001, EXC_ILLEGAL_FUNCTION, 16'h0000);
		cmd(CMD_RESET, EXC_NONE);
		st(CODE_IDLE);
		cmd(CMD_RESET, EXC_ILLEGAL_VALUE);
		// Auto-run mode starts on its own
		@(posedge clk) mode_auto <= 1'b1;
		idle(2);
		st(CODE_COUNTING);
		cmd(CMD_STOP, EXC_ILLEGAL_VALUE);
		cmd(CMD_RESET, EXC_ILLEGAL_VALUE);
		idle(30);
		st(CODE_TIMED_OUT);
		trig();
		st(CODE_COUNTING);
		acc(1'b0, 16'hFA05, 16'h0000, EXC_ILLEGAL_ADDRESS, 16'h0000);
		// Back to explicit control
		@(posedge clk) mode_auto <= 1'b0;
		cmd(CMD_STOP, EXC_NONE);
		st(CODE_IDLE);
		// Status reads trigger only while that option is on
		@(posedge clk) stat_trig <= 1'b1;
		cmd(CMD_START, EXC_NONE);
		repeat (8) st(CODE_COUNTING);
		// Explicit option: external trigger pulses no longer trigger
		@(posedge clk) begin
			stat_trig <= 1'b0;
			exp_trig <= 1'b1;
		end
		repeat (2) begin
			idle(6);
			trig();
		end
		st(CODE_TIMED_OUT);
		check(n_events[25:0], 26'h0000003);
		// Reset while timed out returns to the unconfigured state
		@(posedge clk) rst <= 1'b1;
		idle(2);
		@(posedge clk) rst <= 1'b0;
		st(CODE_NO_TIMEOUT);
		acc(1'b0, ADDR_TIMEOUT_MS, 16'h0000, EXC_NONE, 16'h0000);
		acc(1'b1, ADDR_TIMEOUT_MS, 16'h0003, EXC_NONE, 16'h0000);
		acc(1'b1, ADDR_TIMEOUT_MS, 16'h0000, EXC_NONE, 16'h0000);
		st(CODE_NO_TIMEOUT);
		wrap_up();
	end
endmodule
`default_nettype wire
